//--- cwu_pkg.sv
// package: register map, field positions and reset values of the waveform unit
package cwu_pkg;
  localparam logic [3:0] ADDR_CTRL0      = 4'h0;
  localparam logic [3:0] ADDR_CTRL1      = 4'h4;
  localparam logic [3:0] ADDR_DEADRISE   = 4'h8;
  localparam logic [3:0] ADDR_DEADFALL   = 4'hc;
  localparam logic [3:0] ADDR_OVERRIDE   = 4'h0 + 4'h0;
  localparam int         C0_EN           = 7;
  localparam int         C0_OEB          = 6;
  localparam int         C0_OEA          = 5;
  localparam int         C0_POLB         = 4;
  localparam int         C0_POLA         = 3;
  localparam int         C0_CS           = 0;
  localparam int         C1_OVR_SEL_A    = 7;
  localparam int         C1_OVR_SEL_B    = 6;
  localparam int         C1_OVR_LVL_A    = 5;
  localparam int         C1_OVR_LVL_B    = 4;
  localparam int         C1_IS_LSB       = 0;
  localparam int         DB_WIDTH        = 6;
  localparam int         SRC_COUNT       = 6;
  localparam logic [7:0] CTRL0_RESET     = 8'h00;
  localparam logic [7:0] CTRL1_RESET     = 8'h00;
  localparam logic [5:0] DB_RESET        = 6'h00;
  localparam int         FAST_OSC_MHZ    = 16;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : cwu_pkg

//--- cwu_deadband.sv
// dead-band counter: delays the rising edge of one drive by a programmed count
module cwu_deadband #(
  parameter int W = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick,
  input  wire logic         clear,
  input  wire logic         in_level,
  input  wire logic [W-1:0] delay,
  output logic              out_level
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } cwu_db_state_t;

  cwu_db_state_t s_q;
  cwu_db_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear || !in_level) begin
      s_d.out = 1'b0;
      s_d.cnt = '0;
    end else if (!s_q.out && tick) begin
      if (s_q.cnt >= delay) begin
        s_d.out = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_level = s_q.out;
endmodule : cwu_deadband

//--- cwu_front_end.sv
// complementary waveform unit front end with axi4-lite register slave
// Notes on behaviour
// - working clock is system clock or 16 MHz fast oscillator, one select bit.
// - one input chosen by three-bit selector among six sources.
// - right after enable, both dead-band stages are cleared, so waveforms a and b start low.
// - each pin has its own enable; clear enable releases the pin.
// - enabled pin gets override level or generated waveform per priority select.
// - with module enable clear, output enables and drive levels have no effect.
// - per-output polarity bit: set is active-high, clear is active-low.
// - override levels pass to pins unchanged, ignoring polarity.
// - two complementary outputs with dead time before each off-to-on edge.
// - dead band timed by independent six-bit rising and falling counters.
module cwu_front_end (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        fast_internal_oscillator,
  input  wire logic        pulse_source_one_out,
  input  wire logic        pulse_source_two_out,
  input  wire logic        pulse_source_three_out,
  input  wire logic        pulse_source_four_out,
  input  wire logic        numeric_oscillator_out,
  input  wire logic        logic_cell_out,
  output logic             drive_output_a,
  output logic             drive_output_a_oe_n,
  output logic             drive_output_b,
  output logic             drive_output_b_oe_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [5:0]  db_rise;
    logic [5:0]  db_fall;
    logic        aw_got;
    logic [3:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awready;
    logic        wready;
    logic        arready;
    logic [6:0]  src_s1;
    logic [6:0]  src_s2;
    logic [2:0]  osc_hist;
    logic        en_prev;
    logic        out_a;
    logic        out_a_oe_n;
    logic        out_b;
    logic        out_b_oe_n;
  } cwu_state_t;

  cwu_state_t s_q;
  cwu_state_t s_d;
  logic       tick;
  logic       clear_db;
  logic       sel_in;
  logic       wave_a;
  logic       wave_b;

  function automatic logic reg_mapped(input logic [3:0] a);
    reg_mapped = (a == cwu_pkg::ADDR_CTRL0) || (a == cwu_pkg::ADDR_CTRL1) ||
                 (a == cwu_pkg::ADDR_DEADRISE) || (a == cwu_pkg::ADDR_DEADFALL);
  endfunction : reg_mapped

  function automatic logic src_pick(input logic [2:0] sel, input logic [5:0] src);
    src_pick = (sel < 3'(cwu_pkg::SRC_COUNT)) ? src[sel] : 1'b0;
  endfunction : src_pick

  function automatic logic [7:0] strb_write(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] st);
    strb_write = st[0] ? d[7:0] : old;
  endfunction : strb_write

  function automatic logic pin_drive(input logic ovr_sel, input logic ovr_lvl,
                                     input logic pol, input logic wave);
    if (ovr_sel) begin
      pin_drive = ovr_lvl;
    end else begin
      pin_drive = pol ? wave : ~wave;
    end
  endfunction : pin_drive

  // dead-band tick: system clock, or rising edge of the synchronised fast oscillator
  assign tick = s_q.ctrl0[cwu_pkg::C0_CS] ? (s_q.osc_hist[1] & ~s_q.osc_hist[2])
                                           : 1'b1;
  assign sel_in = src_pick(s_q.ctrl1[cwu_pkg::C1_IS_LSB +: 3], s_q.src_s2[5:0]);
  assign clear_db = !s_q.ctrl0[cwu_pkg::C0_EN] || !s_q.en_prev;

  cwu_deadband #(
    .W (cwu_pkg::DB_WIDTH)
  ) u_rise (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .clear     (clear_db),
    .in_level  (sel_in),
    .delay     (s_q.db_rise),
    .out_level (wave_a)
  );

  cwu_deadband #(
    .W (cwu_pkg::DB_WIDTH)
  ) u_fall (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick),
    .clear     (clear_db),
    .in_level  (~sel_in),
    .delay     (s_q.db_fall),
    .out_level (wave_b)
  );

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for pins from other domains
    s_d.src_s1 = {fast_internal_oscillator, logic_cell_out, numeric_oscillator_out,
                  pulse_source_four_out, pulse_source_three_out, pulse_source_two_out,
                  pulse_source_one_out};
    s_d.src_s2 = s_q.src_s1;
    s_d.osc_hist = {s_q.osc_hist[1:0], s_q.src_s2[6]};
    s_d.en_prev = s_q.ctrl0[cwu_pkg::C0_EN];

    // write channel
    if (!s_q.aw_got && s_axi_awvalid) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (!s_q.w_got && s_axi_wvalid) begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = reg_mapped(s_q.aw_addr) ? cwu_pkg::RESP_OKAY : cwu_pkg::RESP_SLVERR;
      case (s_q.aw_addr)
        cwu_pkg::ADDR_CTRL0: s_d.ctrl0 = strb_write(s_q.ctrl0, s_q.w_data, s_q.w_strb);
        cwu_pkg::ADDR_CTRL1: s_d.ctrl1 = strb_write(s_q.ctrl1, s_q.w_data, s_q.w_strb);
        cwu_pkg::ADDR_DEADRISE: begin
          if (s_q.w_strb[0]) begin
            s_d.db_rise = s_q.w_data[5:0];
          end
        end
        cwu_pkg::ADDR_DEADFALL: begin
          if (s_q.w_strb[0]) begin
            s_d.db_fall = s_q.w_data[5:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // read channel
    if (!s_q.rvalid && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = reg_mapped(s_axi_araddr) ? cwu_pkg::RESP_OKAY : cwu_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        cwu_pkg::ADDR_CTRL0:    s_d.rdata = {24'h000000, s_q.ctrl0};
        cwu_pkg::ADDR_CTRL1:    s_d.rdata = {24'h000000, s_q.ctrl1};
        cwu_pkg::ADDR_DEADRISE: s_d.rdata = {26'h0, s_q.db_rise};
        cwu_pkg::ADDR_DEADFALL: s_d.rdata = {26'h0, s_q.db_fall};
        default:                s_d.rdata = 32'h00000000;
      endcase
      // live state of the drives in bits 9:8 of the control-one readback
      if (s_axi_araddr == cwu_pkg::ADDR_CTRL1) begin
        s_d.rdata[9:8] = {s_q.out_b, s_q.out_a};
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // ready flags kept in flops so the bus outputs come straight from registers
    s_d.awready = !s_d.aw_got;
    s_d.wready = !s_d.w_got;
    s_d.arready = !s_d.rvalid;

    // output stage
    if (!s_q.ctrl0[cwu_pkg::C0_EN]) begin
      s_d.out_a_oe_n = 1'b1;
      s_d.out_b_oe_n = 1'b1;
      s_d.out_a = 1'b0;
      s_d.out_b = 1'b0;
    end else begin
      s_d.out_a_oe_n = !s_q.ctrl0[cwu_pkg::C0_OEA];
      s_d.out_b_oe_n = !s_q.ctrl0[cwu_pkg::C0_OEB];
      s_d.out_a = pin_drive(s_q.ctrl1[cwu_pkg::C1_OVR_SEL_A], s_q.ctrl1[cwu_pkg::C1_OVR_LVL_A],
                            s_q.ctrl0[cwu_pkg::C0_POLA], wave_a);
      s_d.out_b = pin_drive(s_q.ctrl1[cwu_pkg::C1_OVR_SEL_B], s_q.ctrl1[cwu_pkg::C1_OVR_LVL_B],
                            s_q.ctrl0[cwu_pkg::C0_POLB], wave_b);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.ctrl0      <= cwu_pkg::CTRL0_RESET;
      s_q.ctrl1      <= cwu_pkg::CTRL1_RESET;
      s_q.db_rise    <= cwu_pkg::DB_RESET;
      s_q.db_fall    <= cwu_pkg::DB_RESET;
      s_q.aw_got     <= 1'b0;
      s_q.aw_addr    <= 4'h0;
      s_q.w_got      <= 1'b0;
      s_q.w_data     <= 32'h00000000;
      s_q.w_strb     <= 4'h0;
      s_q.bvalid     <= 1'b0;
      s_q.bresp      <= cwu_pkg::RESP_OKAY;
      s_q.rvalid     <= 1'b0;
      s_q.rdata      <= 32'h00000000;
      s_q.rresp      <= cwu_pkg::RESP_OKAY;
      s_q.awready    <= 1'b1;
      s_q.wready     <= 1'b1;
      s_q.arready    <= 1'b1;
      s_q.src_s1     <= 7'h00;
      s_q.src_s2     <= 7'h00;
      s_q.osc_hist   <= 3'h0;
      s_q.en_prev    <= 1'b0;
      s_q.out_a      <= 1'b0;
      s_q.out_a_oe_n <= 1'b1;
      s_q.out_b      <= 1'b0;
      s_q.out_b_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign drive_output_a      = s_q.out_a;
  assign drive_output_a_oe_n = s_q.out_a_oe_n;
  assign drive_output_b      = s_q.out_b;
  assign drive_output_b_oe_n = s_q.out_b_oe_n;
  assign s_axi_awready       = s_q.awready;
  assign s_axi_wready        = s_q.wready;
  assign s_axi_bvalid        = s_q.bvalid;
  assign s_axi_bresp         = s_q.bresp;
  assign s_axi_arready       = s_q.arready;
  assign s_axi_rvalid        = s_q.rvalid;
  assign s_axi_rdata         = s_q.rdata;
  assign s_axi_rresp         = s_q.rresp;
endmodule : cwu_front_end

//--- cwu_chk.sv
// checker: port-level assertions of the waveform unit
module cwu_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        drive_output_a,
  input wire logic        drive_output_a_oe_n,
  input wire logic        drive_output_b_oe_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_release: assert property (disable iff (1'b0) !aresetn |=>
    drive_output_a_oe_n && drive_output_b_oe_n && !drive_output_a) else $error("pins not released");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high");
  a_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("bad read response");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_drive_a: cover property ($rose(drive_output_a));
endmodule : cwu_chk

bind cwu_front_end cwu_chk u_chk (.*);

//--- cwu_switch_model.sv
// partner: gate input of one external power switch, pulled down when the pin is released
module cwu_switch_model (
  input  wire logic pin,
  input  wire logic oe_n,
  output logic      gate
);
  assign gate = oe_n ? 1'b0 : pin;
endmodule : cwu_switch_model

//--- cwu_tb.sv
// testbench: register-driven pin scenarios of the waveform unit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] c0; logic [7:0] c1; logic [5:0] src; logic [3:0] e;} cwu_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [5:0] src = 6'h00;
  logic [2:0] oc = 3'h0;
  logic pulse_source_one_out, pulse_source_two_out, pulse_source_three_out, fast_internal_oscillator;
  logic pulse_source_four_out, numeric_oscillator_out, logic_cell_out, drive_output_a, drive_output_b;
  logic drive_output_a_oe_n, drive_output_b_oe_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, gate_a, gate_b;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  int errors = 0, tests_run = 0, lat = 0;
  cwu_row_t rows [7] = '{'{8'h78, 8'h00, 6'h01, 4'ha}, '{8'ha8, 8'h00, 6'h01, 4'h6},
    '{8'hf8, 8'h00, 6'h00, 4'h1}, '{8'hf8, 8'h00, 6'h01, 4'h4}, '{8'he0, 8'h00, 6'h01, 4'h1},
    '{8'he0, 8'he0, 6'h01, 4'h4}, '{8'ha9, 8'h00, 6'h01, 4'h6}};
  assign {logic_cell_out, numeric_oscillator_out, pulse_source_four_out, pulse_source_three_out,
    pulse_source_two_out, pulse_source_one_out} = src;
  assign fast_internal_oscillator = oc[2];
  cwu_front_end DUT (.*);
  cwu_switch_model u_sw_a (.pin(drive_output_a), .oe_n(drive_output_a_oe_n), .gate(gate_a));
  cwu_switch_model u_sw_b (.pin(drive_output_b), .oe_n(drive_output_b_oe_n), .gate(gate_b));
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    oc <= oc + 3'h1;
  end
  task automatic print_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, v}; s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask : rd
  task automatic wait_gate(input logic use_b, output int cnt);
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while ((use_b ? gate_b : gate_a) !== 1'b1 && cnt < 100);
    if (cnt >= 100) begin
      errors++;
      print_verdict();
    end
  endtask : wait_gate
  task automatic run(input cwu_row_t r);
    src <= r.src;
    wr(4'h4, r.c1);
    wr(4'h0, r.c0);
    repeat (40) @(posedge aclk);
    chk({28'h0, drive_output_a_oe_n, gate_a, drive_output_b_oe_n, gate_b}, {28'h0, r.e});
  endtask : run
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, d);
    chk(d, 32'h0);
    src <= 6'h01;
    wr(4'h0, 8'ha8);
    repeat (2) @(posedge aclk);
    chk({30'h0, drive_output_a_oe_n, drive_output_a}, 32'h0);
    // pin rows cover enables, polarity, override, clock select and dead-time complement
    foreach (rows[i]) run(rows[i]);
    for (int k = 0; k < 8; k++) begin
      run('{8'ha8, 8'(k), 6'h01 << k, (k < 6) ? 4'h6 : 4'h2});
      run('{8'ha8, 8'(k), ~(6'h01 << k), 4'h2});
    end
    src <= 6'h00;
    wr(4'h8, 8'h05);
    wr(4'hc, 8'h03);
    rd(4'h8, d);
    chk({d[29:0], resp}, 32'h00000014);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'hf8);
    repeat (10) @(posedge aclk);
    src <= 6'h01;
    wait_gate(1'b0, lat);
    chk(lat, 32'd10);
    src <= 6'h00;
    wait_gate(1'b1, lat);
    chk(lat, 32'd8);
    wr(4'h0, 8'hf9);
    src <= 6'h01;
    wait_gate(1'b0, lat);
    chk({31'h0, lat >= 45 && lat <= 52}, 32'h1);
    rd(4'h4, d);
    chk(d, 32'h00000100);
    wr(4'h2, 8'hff);
    chk({30'h0, resp}, 32'h2);
    rd(4'h2, d);
    chk({d[29:0], resp}, 32'h2);
    rd(4'h0, d);
    chk(d, 32'h000000f9);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, drive_output_a_oe_n, drive_output_b_oe_n}, 32'h3);
    rd(4'h0, d);
    chk(d, 32'h0);
    print_verdict();
  end
endmodule : testbench
